// [src/eecc_pkg.sv]
// Package of the EEPROM command controller: offsets, field layout,
// reset values, states and the request carried to the serial engine.
// Assumes a byte-wide serial EEPROM engine outside this block.
package eecc_pkg;

    // Register byte offsets.
    localparam logic [11:0] CMD_OFFSET  = 12'h1b4;
    localparam logic [11:0] DATA_OFFSET = 12'h1b8;

    // Field positions inside the command register.
    localparam int BUSY_BIT     = 31;
    localparam int OP_MSB       = 30;
    localparam int OP_LSB       = 28;
    localparam int TIMEOUT_BIT  = 17;
    localparam int OVERFLOW_BIT = 16;
    localparam int ADDR_MSB     = 15;
    localparam int ADDR_LSB     = 0;

    // Widths of the fields.
    localparam int OP_W   = 3;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Values after reset.
    localparam logic             BUSY_RST = 1'b1;
    localparam logic [OP_W-1:0]  OP_RST   = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // Operation that reads one byte.
    localparam logic [OP_W-1:0] OP_READ = 3'h0;

    // Controller states, one-hot.
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b010,
        ST_CMD  = 3'b100
    } eecc_state_e;

    // Request handed to the serial engine.
    typedef struct packed {
        logic [OP_W-1:0]   op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eecc_req_s;

endpackage

// [src/eecc_top.sv]
// EEPROM command controller: command and data registers, busy handshake,
// the boot-time byte fetch loop and the request port of the serial engine.
// Assumes the engine, the loader's parser and software share clk.
//
// Behaviour
// (RULE_01) Writing one to busy runs the selected operation at the given address.
// (RULE_02) Busy stays set until the operation completes, then self-clears.
// (RULE_03) For a read, busy clearing means the fetched byte is in data register.
// (RULE_04) Software leaves command and data registers alone while busy is set.
// (RULE_05) A write with no EEPROM keeps busy until timeout flag sets, then clears.
// (RULE_06) Busy is forced to one after any reset.
// (RULE_07) After reset busy clears only when the boot loader has finished.
// (RULE_08) The three-bit operation field acts only with busy set; resets to zero.
// (RULE_09) Software issues no new command until the previous one completed.
// (RULE_10) Loader stops and flags overflow when the EEPROM address limit passes.
// (RULE_11) Loader completion may signal an interrupt-style completion pulse.
// (RULE_12) Writing zero to busy does nothing; an operation cannot be aborted.
`timescale 1ns/1ps
`default_nettype none

module eecc_top #(
    parameter int ADDR_W = eecc_pkg::ADDR_W
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Register port.
    input  wire logic [11:0]                  reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [31:0]                  reg_rdata,
    // Serial engine request and answer.
    output logic                              eng_req,
    output eecc_pkg::eecc_req_s               eng_cmd,
    input  wire logic                         eng_done,
    input  wire logic                         eng_timeout,
    input  wire logic [eecc_pkg::DATA_W-1:0]  eng_rdata,
    // Boot loader byte stream and its parser.
    input  wire logic [ADDR_W-1:0]            size_limit,
    output logic                              ld_valid,
    output logic      [eecc_pkg::DATA_W-1:0]  ld_byte,
    input  wire logic                         ld_finish,
    output logic                              ld_done_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check and declarations.

    initial begin
        if (ADDR_W != eecc_pkg::ADDR_W) begin
            $error("eecc_top: ADDR_W must equal the command address field");
        end
    end

    eecc_pkg::eecc_state_e              state_q;
    logic                               busy_q;
    logic [eecc_pkg::OP_W-1:0]          op_q;
    logic [ADDR_W-1:0]                  addr_q;
    logic [eecc_pkg::DATA_W-1:0]        data_q;
    logic                               timeout_q;
    logic                               overflow_q;
    logic [ADDR_W-1:0]                  ld_addr_q;
    logic                               ld_wait_q;
    logic                               cmd_wr;
    logic                               data_wr;
    logic                               start;
    logic [31:0]                        cmd_word;
    logic                               ld_ready;

    // Decode of register writes; data, operation and address are frozen while busy.
    assign cmd_wr  = reg_wr && (reg_addr == eecc_pkg::CMD_OFFSET);
    assign data_wr = reg_wr && (reg_addr == eecc_pkg::DATA_OFFSET) && !busy_q;
    assign start   = cmd_wr && !busy_q && reg_wdata[eecc_pkg::BUSY_BIT]; // [RULE_01] [RULE_12]

    // The loader waits one cycle after each byte so that a finish from the
    // parser lands before the next fetch and no request is left open.
    assign ld_ready = !ld_wait_q && !ld_valid;

    // Image of the command register as software reads it.
    always_comb begin
        cmd_word = 32'h0000_0000;
        cmd_word[eecc_pkg::BUSY_BIT] = busy_q;
        cmd_word[eecc_pkg::OP_MSB:eecc_pkg::OP_LSB] = op_q;
        cmd_word[eecc_pkg::TIMEOUT_BIT] = timeout_q;
        cmd_word[eecc_pkg::OVERFLOW_BIT] = overflow_q;
        cmd_word[eecc_pkg::ADDR_MSB:eecc_pkg::ADDR_LSB] = addr_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // State sequence: boot loading, idle, command in flight.

    // The loader runs first after every reset; commands wait for idle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= eecc_pkg::ST_LOAD; // [RULE_07]
        end else begin
            case (state_q)
                eecc_pkg::ST_LOAD: begin
                    if (ld_finish || (ld_ready && ld_addr_q > size_limit)) begin
                        state_q <= eecc_pkg::ST_IDLE; // [RULE_07] [RULE_10]
                    end
                end
                eecc_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= eecc_pkg::ST_CMD; // [RULE_08]
                    end
                end
                eecc_pkg::ST_CMD: begin
                    if (eng_done || eng_timeout) begin
                        state_q <= eecc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= eecc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy flag.

    // Set by reset and by a start; cleared only by completion, not software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= eecc_pkg::BUSY_RST; // [RULE_06]
        end else if (start) begin
            busy_q <= 1'b1; // [RULE_01]
        end else if (state_q == eecc_pkg::ST_CMD && (eng_done || eng_timeout)) begin
            busy_q <= 1'b0; // [RULE_02] [RULE_05]
        end else if (state_q == eecc_pkg::ST_LOAD
                     && (ld_finish || (ld_ready && ld_addr_q > size_limit))) begin
            busy_q <= 1'b0; // [RULE_07]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command fields: operation and address.

    // Writes are ignored while busy so an operation in flight stays intact.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q   <= eecc_pkg::OP_RST; // [RULE_08]
            addr_q <= eecc_pkg::ADDR_RST;
        end else if (cmd_wr && !busy_q) begin // [RULE_04] [RULE_09]
            op_q   <= reg_wdata[eecc_pkg::OP_MSB:eecc_pkg::OP_LSB];
            addr_q <= reg_wdata[eecc_pkg::ADDR_MSB:eecc_pkg::ADDR_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data register.

    // A read completion loads the fetched byte in the cycle busy clears.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= eecc_pkg::DATA_RST;
        end else if (state_q == eecc_pkg::ST_CMD && eng_done
                     && op_q == eecc_pkg::OP_READ) begin
            data_q <= eng_rdata; // [RULE_03]
        end else if (data_wr) begin
            data_q <= reg_wdata[eecc_pkg::DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status flags.

    // Timeout sets with busy clearing; a one written clears it, set wins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_q <= 1'b0;
        end else if (state_q == eecc_pkg::ST_CMD && eng_timeout) begin
            timeout_q <= 1'b1; // [RULE_05]
        end else if (cmd_wr && reg_wdata[eecc_pkg::TIMEOUT_BIT]) begin
            timeout_q <= 1'b0;
        end
    end

    // Overflow marks a loader that ran past the size limit; cleared by a one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_q <= 1'b0;
        end else if (state_q == eecc_pkg::ST_LOAD && !ld_finish
                     && ld_ready && ld_addr_q > size_limit) begin
            overflow_q <= 1'b1; // [RULE_10]
        end else if (cmd_wr && reg_wdata[eecc_pkg::OVERFLOW_BIT]) begin
            overflow_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot loader fetch loop.

    // Fetches bytes from address zero upward, one engine read at a time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_addr_q <= '0;
            ld_wait_q <= 1'b0;
        end else if (state_q == eecc_pkg::ST_LOAD && !ld_finish) begin
            if (ld_ready && ld_addr_q <= size_limit) begin
                ld_wait_q <= 1'b1;
            end else if (ld_wait_q && (eng_done || eng_timeout)) begin
                ld_wait_q <= 1'b0;
                ld_addr_q <= ld_addr_q + 1'b1;
            end
        end else begin
            ld_wait_q <= 1'b0;
        end
    end

    // Byte stream to the parser and the completion pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_valid      <= 1'b0;
            ld_byte       <= eecc_pkg::DATA_RST;
            ld_done_pulse <= 1'b0;
        end else begin
            ld_valid      <= state_q == eecc_pkg::ST_LOAD && ld_wait_q
                             && eng_done && !ld_finish;
            ld_done_pulse <= state_q == eecc_pkg::ST_LOAD && (ld_finish
                             || (ld_ready && ld_addr_q > size_limit)); // [RULE_11]
            if (state_q == eecc_pkg::ST_LOAD && ld_wait_q && eng_done) begin
                ld_byte <= eng_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine request.

    // One-cycle request with the operation held stable in eng_cmd.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng_req <= 1'b0;
            eng_cmd <= '0;
        end else begin
            eng_req <= 1'b0;
            if (start) begin
                eng_req       <= 1'b1; // [RULE_01]
                eng_cmd.op    <= reg_wdata[eecc_pkg::OP_MSB:eecc_pkg::OP_LSB];
                eng_cmd.addr  <= reg_wdata[eecc_pkg::ADDR_MSB:eecc_pkg::ADDR_LSB];
                eng_cmd.wdata <= data_q;
            end else if (state_q == eecc_pkg::ST_LOAD && !ld_finish
                         && ld_ready && ld_addr_q <= size_limit) begin
                eng_req       <= 1'b1;
                eng_cmd.op    <= eecc_pkg::OP_READ;
                eng_cmd.addr  <= ld_addr_q;
                eng_cmd.wdata <= eecc_pkg::DATA_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port.

    // Read data stand in the cycle after the strobe; unmapped reads give 0.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == eecc_pkg::CMD_OFFSET) begin
            reg_rdata <= cmd_word;
        end else if (reg_rd && reg_addr == eecc_pkg::DATA_OFFSET) begin
            reg_rdata <= {24'h000000, data_q};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// [verification/eecc_assertions.sv]
// Checker of the EEPROM command controller, bound to its top ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module eecc_checker (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [11:0]         reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    input wire logic                eng_req,
    input wire eecc_pkg::eecc_req_s eng_cmd,
    input wire logic                eng_done,
    input wire logic                eng_timeout,
    input wire logic [7:0]          eng_rdata,
    input wire logic                ld_valid,
    input wire logic [7:0]          ld_byte,
    input wire logic                ld_finish,
    input wire logic                ld_done_pulse
);
    logic ld_q, out_q, fin_q, tmo_q, cmd_go, cmd_rd;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign cmd_go = reg_wr && reg_addr == eecc_pkg::CMD_OFFSET && reg_wdata[31];
    assign cmd_rd = reg_rd && reg_addr == eecc_pkg::CMD_OFFSET;
    // Tracks loading, the open request, a finished command and timeout.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_q  <= 1'b1;
            out_q <= 1'b0;
            fin_q <= 1'b0;
            tmo_q <= 1'b0;
        end else begin
            if (ld_finish || ld_done_pulse) ld_q <= 1'b0;
            out_q <= eng_req || (out_q && !eng_done && !eng_timeout);
            if (cmd_go) fin_q <= 1'b0;
            else if ((eng_done || eng_timeout) && out_q && !ld_q) fin_q <= 1'b1;
            if (eng_timeout && out_q) tmo_q <= 1'b1;
            else if (reg_wr && reg_addr == eecc_pkg::CMD_OFFSET && reg_wdata[17])
                tmo_q <= 1'b0;
        end
    end
    chk_one_open: assert property (eng_req |-> !out_q)
        else $error("request issued while one is open");
    chk_cmd_start: assert property (eng_req && !ld_q |-> $past(cmd_go))
        else $error("request without a busy write");
    chk_cmd_fields: assert property (eng_req && !ld_q |->
        eng_cmd.op == $past(reg_wdata[30:28]) && eng_cmd.addr == $past(reg_wdata[15:0]))
        else $error("request fields differ from command");
    chk_busy_held: assert property (cmd_rd && out_q && !eng_done && !eng_timeout |=> reg_rdata[31])
        else $error("busy low during operation");
    chk_busy_load: assert property (cmd_rd && ld_q && !ld_finish && !ld_done_pulse |=> reg_rdata[31])
        else $error("busy low during loading");
    chk_load_clear: assert property (cmd_rd && ld_done_pulse |=> !reg_rdata[31])
        else $error("busy set after loading");
    chk_load_done: assert property (ld_finish && ld_q |=> ld_done_pulse ##1 !ld_done_pulse)
        else $error("completion pulse wrong");
    chk_byte_pass: assert property (ld_valid |-> $past(eng_done) && ld_byte == $past(eng_rdata))
        else $error("loader byte wrong");
    chk_cmd_clear: assert property (cmd_rd && fin_q && !cmd_go |=> !reg_rdata[31])
        else $error("busy set after completion");
    chk_tmo_flag: assert property (cmd_rd && tmo_q |=> reg_rdata[17])
        else $error("timeout flag missing");
    cover property (cmd_go);
    cover property (eng_timeout && out_q);
    cover property (ld_done_pulse);
endmodule
bind eecc_top eecc_checker i_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .eng_req, .eng_cmd, .eng_done, .eng_timeout,
    .eng_rdata, .ld_valid, .ld_byte, .ld_finish, .ld_done_pulse);
`default_nettype wire

// [verification/eecc_eeprom_model.sv]
// Behavioural serial EEPROM engine answering the controller's requests.
// Assumes the controller's clock; answers each request exactly once.
`timescale 1ns/1ps
`default_nettype none
module eecc_eeprom_model (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                eng_req,
    input  wire eecc_pkg::eecc_req_s eng_cmd,
    input  wire logic                present,
    input  wire logic                slow,
    output logic                     eng_done,
    output logic                     eng_timeout,
    output logic [7:0]               eng_rdata
);
    logic [3:0] cnt_q;
    logic       act_q;
    // Waits the access time, then answers; data toggle outside done.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q       <= 1'b0;
            cnt_q       <= 4'h0;
            eng_done    <= 1'b0;
            eng_timeout <= 1'b0;
            eng_rdata   <= 8'h00;
        end else begin
            eng_done    <= 1'b0;
            eng_timeout <= 1'b0;
            eng_rdata   <= ~eng_rdata;
            if (eng_req) begin
                act_q <= 1'b1;
                cnt_q <= slow ? 4'h9 : 4'h1;
            end else if (act_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (act_q) begin
                act_q       <= 1'b0;
                eng_done    <= present;
                eng_timeout <= !present;
                eng_rdata   <= eng_cmd.addr[7:0] ^ 8'h5a;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/test_eeprom_command_control.sv]
// Testbench of the EEPROM command controller with an engine model.
// Assumes the checker is bound to the controller's top.
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_command_control;
    localparam logic [11:0] CMD = eecc_pkg::CMD_OFFSET;
    logic                clk, rst_n, reg_wr, reg_rd, present, slow;
    logic                eng_req, eng_done, eng_timeout, ld_finish;
    logic                ld_valid, ld_done_pulse;
    logic [11:0]         reg_addr;
    logic [31:0]         reg_wdata, reg_rdata, rd_v;
    logic [15:0]         size_limit;
    logic [7:0]          eng_rdata, ld_byte;
    eecc_pkg::eecc_req_s eng_cmd;
    int                  n_mismatch, num_checks, nvalid, ndone;
    eecc_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .eng_req, .eng_cmd, .eng_done, .eng_timeout, .eng_rdata,
        .size_limit, .ld_valid, .ld_byte, .ld_finish, .ld_done_pulse);
    eecc_eeprom_model i_mem (.clk, .rst_n, .eng_req, .eng_cmd, .present,
        .slow, .eng_done, .eng_timeout, .eng_rdata);
    ////////////////////////////////////////////////////////////////////////
    // Makes the clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Parser: ends the boot load after three bytes; counts completions.
    always @(posedge clk) begin
        if (ld_valid) nvalid <= nvalid + 1;
        if (ld_done_pulse) ndone <= ndone + 1;
        ld_finish <= ld_valid && nvalid == 2;
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // Polls busy under a bound; software never issues while busy.
    task automatic wait_idle();
        int i;
        for (i = 0; i < 100; i++) begin
            rd(CMD);
            if (rd_v[31] === 1'b0) break;
        end
        check("busy wait", 32'(i == 100), 32'h0);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(CMD);
        check("busy after reset", rd_v & 32'hf000_0000, 32'h8000_0000);
        wait_idle();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Cuts a hang short.
    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
    // Runs the tests in order.
    initial begin
        {reg_wr, reg_rd, slow} = '0;
        {reg_addr, reg_wdata, rd_v} = '0;
        present = 1'b1;
        size_limit = 16'hffff;
        do_reset();
        check("load pulses", ndone, 1);
        $display("test boot load done");
        slow <= 1'b1;
        wr(CMD, 32'h8000_0012);
        wr(CMD, 32'h0000_0012);
        rd(CMD);
        check("busy held", rd_v[31], 1'b1);
        wait_idle();
        rd(eecc_pkg::DATA_OFFSET);
        check("read byte", rd_v, 32'h0000_0048);
        slow <= 1'b0;
        for (int op = 0; op < 8; op++) begin
            wr(CMD, {1'b1, op[2:0], 12'h000, 16'h0040 + op[15:0]});
            wait_idle();
            check("op code", 32'(eng_cmd.op), 32'(op[2:0]));
        end
        $display("test commands done");
        present <= 1'b0;
        wr(eecc_pkg::DATA_OFFSET, 32'h0000_00a7);
        wr(CMD, 32'h9000_0033);
        wait_idle();
        check("write data", 32'(eng_cmd.wdata), 32'h0000_00a7);
        check("timeout", rd_v & 32'h8002_0000, 32'h0002_0000);
        present <= 1'b1;
        wr(CMD, 32'h0002_0000);
        rd(CMD);
        check("timeout cleared", rd_v[17], 1'b0);
        rd(12'h1bc);
        check("unmapped", rd_v, 32'h0);
        $display("test timeout done");
        size_limit <= 16'h0001;
        do_reset();
        check("overflow", rd_v & 32'h8001_0000, 32'h0001_0000);
        check("load pulses", ndone, 2);
        $display("test overflow done");
        wrap_up();
    end
endmodule
`default_nettype wire
